// ===== pgs_defines.svh
// constants for the port a gpio block with peripheral pin steering
// Summary of operation
// - latch writes equal pin level register writes
// - latch read returns latches, port reads pins
// - direction one tristates, zero drives latch
// - bit three input only, direction reads one
// - six bit port, upper bits read zero
// - port writes are read modify write
// - direction still controls driver in analog
// - analog selected pins read zero
// - threshold select feeds reads and change detect
// - threshold one schmitt, zero ttl
// - six individual weak pull-up enables
// - pull-up off while pin is output
// - reset sets global pull-up disable
// - individual pull-ups need global disable clear
// - analog select forces digital reads zero
// - analog select leaves digital output working
// - steering leaves direction untouched, routes overrides
// - steer0 bit7 moves serial receive pin
// - steer0 bits 6,5 move spi out, select
// - steer0 bit3 moves timer gate input
// - steer0 bit2 moves serial transmit pin
// - steer1 bits 3,2 move pwm d, c
// - steer1 bit1 moves pwm2 b
// - steer1 bit0 moves capture2 pwm2 a
`ifndef PGS_DEFINES_SVH
`define PGS_DEFINES_SVH

// register byte offsets
`define PGS_OFF_PIN_LEVEL   8'h00
`define PGS_OFF_LATCH       8'h04
`define PGS_OFF_DIRECTION   8'h08
`define PGS_OFF_ANALOG      8'h0c
`define PGS_OFF_THRESHOLD   8'h10
`define PGS_OFF_PULLUP      8'h14
`define PGS_OFF_GLOBAL_PU   8'h18
`define PGS_OFF_STEER0      8'h1c
`define PGS_OFF_STEER1      8'h20

// reset values
`define PGS_RST_LATCH       8'h00
`define PGS_RST_DIRECTION   8'h3f
`define PGS_RST_ANALOG      8'h17
`define PGS_RST_THRESHOLD   8'h04
`define PGS_RST_PULLUP      8'h3f
`define PGS_RST_GLOBAL_PU   1'b1
`define PGS_RST_STEER       8'h00

// implemented bit masks
`define PGS_MASK_PIN        8'h3f
`define PGS_MASK_LATCH      8'h37
`define PGS_MASK_DIR_WR     8'h37
`define PGS_DIR_FIXED       8'h08
`define PGS_MASK_ANALOG     8'h17
`define PGS_MASK_STEER0     8'hec
`define PGS_MASK_STEER1     8'h0f
`define PGS_INPUT_ONLY      6'h08

// field positions
`define PGS_BIT_GLOBAL_PU   7
`define PGS_BIT_RX_SEL      7
`define PGS_BIT_SDO_SEL     6
`define PGS_BIT_SS_SEL      5
`define PGS_BIT_GATE_SEL    3
`define PGS_BIT_TX_SEL      2
`define PGS_BIT_PWM_D_SEL   3
`define PGS_BIT_PWM_C_SEL   2
`define PGS_BIT_PWM2_B_SEL  1
`define PGS_BIT_CAP2_SEL    0

`endif

// ===== pgs_pad_model.sv
// behavioural model of the port a pads and the board behind them
`timescale 1ns/1ps
`default_nettype none
module pgs_pad_model (
    input  wire pgs_pkg::pgs_pin_t out_i,    // drive value from the block
    input  wire pgs_pkg::pgs_pin_t oe_i,     // driver enable from the block
    input  wire pgs_pkg::pgs_pin_t pullup_i, // weak pull-up on
    input  wire pgs_pkg::pgs_pin_t ext_i,    // board level
    input  wire pgs_pkg::pgs_pin_t ext_en_i, // board drives the pin
    input  wire pgs_pkg::pgs_pin_t skew_i,   // pins sitting between thresholds
    input  wire logic              clk_i,    // system clock
    output logic [5:0]             st_o,     // schmitt buffer level
    output logic [5:0]             ttl_o     // ttl buffer level
);
    logic [5:0] float_q = 6'h15; // undriven pins wander every cycle
    logic [5:0] level;           // resolved pad level
    always @(posedge clk_i) float_q <= ~float_q;
    // block driver first, then board, then pull-up, else wandering
    assign level = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
                 | (~oe_i & ~ext_en_i & (pullup_i | float_q));
    assign st_o  = level;
    assign ttl_o = level ^ skew_i;
endmodule : pgs_pad_model
`default_nettype wire

// ===== pgs_pkg.sv
// types shared by the port a gpio block
`default_nettype none
package pgs_pkg;
    typedef logic [5:0]  pgs_pin_t;    // one bit per port pin
    typedef logic [7:0]  pgs_reg_t;    // one register byte
    typedef logic [7:0]  pgs_addr_t;   // bus byte address
    typedef logic [31:0] pgs_word_t;   // bus data word
endpackage : pgs_pkg
`default_nettype wire

// ===== pgs_port_a.sv
// port a gpio logic with peripheral pin steering behind an apb slave
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pgs_defines.svh"
module pgs_port_a (
    input  wire logic             mclk_i,            // system clock, 10 MHz
    input  wire logic             reset_n_i,         // asynchronous reset, active low
    // apb slave
    input  wire logic             psel_i,            // slave select
    input  wire logic             penable_i,         // access phase
    input  wire logic             pwrite_i,          // write when high
    input  wire pgs_pkg::pgs_addr_t paddr_i,         // byte address
    input  wire pgs_pkg::pgs_word_t pwdata_i,        // write data
    input  wire logic [3:0]       pstrb_i,           // byte lane strobes
    output logic                  pready_o,          // access done
    output pgs_pkg::pgs_word_t    prdata_o,          // read data
    output logic                  pslverr_o,         // unmapped address
    // port a pad side
    input  wire pgs_pkg::pgs_pin_t pa_st_i,          // schmitt buffer levels
    input  wire pgs_pkg::pgs_pin_t pa_ttl_i,         // ttl buffer levels
    output pgs_pkg::pgs_pin_t     pa_out_o,          // pin drive value
    output pgs_pkg::pgs_pin_t     pa_oe_o,           // pin driver enable
    output pgs_pkg::pgs_pin_t     pa_pullup_o,       // weak pull-up on
    output pgs_pkg::pgs_pin_t     pa_analog_o,       // analog input mode
    output pgs_pkg::pgs_pin_t     pa_sense_o,        // digital input for change detect
    // port c pad levels and overrides
    input  wire pgs_pkg::pgs_pin_t pc_pin_i,         // port c pin levels
    output pgs_pkg::pgs_pin_t     pc_ovr_en_o,       // port c peripheral override
    output pgs_pkg::pgs_pin_t     pc_ovr_val_o,      // port c override value
    // peripheral outputs to be steered
    input  wire logic             serial_receive_data_out_i,       // serial data in sync mode
    input  wire logic             serial_receive_data_oe_i,
    input  wire logic             serial_transmit_clock_out_i,       // serial transmit or clock
    input  wire logic             serial_transmit_clock_oe_i,
    input  wire logic             sdo_out_i,         // spi data out
    input  wire logic             sdo_oe_i,
    input  wire logic             pwm_c_out_i,       // pwm output c
    input  wire logic             pwm_c_oe_i,
    input  wire logic             pwm_d_out_i,       // pwm output d
    input  wire logic             pwm_d_oe_i,
    input  wire logic             pwm2_b_out_i,      // pwm2 output b
    input  wire logic             pwm2_b_oe_i,
    input  wire logic             cap2_out_i,        // capture2 / pwm2 a
    input  wire logic             cap2_oe_i,
    // steered inputs to peripherals
    output logic                  serial_receive_data_in_o,        // serial receive data
    output logic                  serial_transmit_clock_in_o,        // serial clock in
    output logic                  slave_select_in_o, // spi slave select
    output logic                  timer_gate_in_o,   // timer gate input
    output logic                  cap2_in_o          // capture2 input
);

    // address match, used for every register
    function automatic logic reg_hit(input pgs_pkg::pgs_addr_t addr,
                                     input pgs_pkg::pgs_addr_t off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    // ---------------- registers ----------------
    pgs_pkg::pgs_reg_t lat_q;        // output latch
    pgs_pkg::pgs_reg_t dir_q;        // direction, 1 = input
    pgs_pkg::pgs_reg_t ans_q;        // analog select
    pgs_pkg::pgs_reg_t lvl_q;        // input threshold select
    pgs_pkg::pgs_reg_t wpu_q;        // pull-up enables
    logic              gpd_q;        // global pull-up disable
    pgs_pkg::pgs_reg_t st0_q;        // steering register 0
    pgs_pkg::pgs_reg_t st1_q;        // steering register 1
    logic              pready_q;     // answer flag
    pgs_pkg::pgs_word_t prdata_q;    // captured read data
    logic              pslverr_q;    // error answer

    // ---------------- synchronisers ----------------
    pgs_pkg::pgs_pin_t st_s1_q, st_s2_q;    // schmitt levels
    pgs_pkg::pgs_pin_t ttl_s1_q, ttl_s2_q;  // ttl levels
    pgs_pkg::pgs_pin_t pc_s1_q, pc_s2_q;    // port c levels

    // ---------------- pin side registers ----------------
    pgs_pkg::pgs_pin_t pa_out_q, pa_oe_q, pa_pu_q, pa_sense_q;
    pgs_pkg::pgs_pin_t pc_en_q, pc_val_q;
    logic rx_in_q, ck_in_q, ss_in_q, gate_in_q, cap_in_q;

    // ---------------- bus decode ----------------
    wire logic acc_first = psel_i & penable_i & ~pready_q; // first access cycle
    wire logic acc_take  = psel_i & penable_i & pready_q;  // completing edge
    wire logic lane0     = pstrb_i[0];                     // low byte addressed
    wire logic hit_pin = reg_hit(paddr_i, `PGS_OFF_PIN_LEVEL);
    wire logic hit_lat = reg_hit(paddr_i, `PGS_OFF_LATCH);
    wire logic hit_dir = reg_hit(paddr_i, `PGS_OFF_DIRECTION);
    wire logic hit_ans = reg_hit(paddr_i, `PGS_OFF_ANALOG);
    wire logic hit_lvl = reg_hit(paddr_i, `PGS_OFF_THRESHOLD);
    wire logic hit_wpu = reg_hit(paddr_i, `PGS_OFF_PULLUP);
    wire logic hit_gpd = reg_hit(paddr_i, `PGS_OFF_GLOBAL_PU);
    wire logic hit_st0 = reg_hit(paddr_i, `PGS_OFF_STEER0);
    wire logic hit_st1 = reg_hit(paddr_i, `PGS_OFF_STEER1);
    wire logic hit_any = hit_pin | hit_lat | hit_dir | hit_ans | hit_lvl
                       | hit_wpu | hit_gpd | hit_st0 | hit_st1;
    wire logic wr_go   = acc_take & pwrite_i;              // write commits here
    wire logic wr_pin  = wr_go & hit_pin;
    wire logic wr_lat  = wr_go & hit_lat & lane0;
    wire logic wr_dir  = wr_go & hit_dir & lane0;
    wire logic wr_ans  = wr_go & hit_ans & lane0;
    wire logic wr_lvl  = wr_go & hit_lvl & lane0;
    wire logic wr_wpu  = wr_go & hit_wpu & lane0;
    wire logic wr_gpd  = wr_go & hit_gpd & lane0;
    wire logic wr_st0  = wr_go & hit_st0 & lane0;
    wire logic wr_st1  = wr_go & hit_st1 & lane0;
    wire pgs_pkg::pgs_reg_t wbyte = pwdata_i[7:0];

    // ---------------- input sensing ----------------
    // threshold select picks schmitt (1) or ttl (0) per pin
    wire pgs_pkg::pgs_pin_t pa_sel = (lvl_q[5:0] & st_s2_q)
                                   | (~lvl_q[5:0] & ttl_s2_q);
    // analog pins have the digital buffer off and read zero
    wire pgs_pkg::pgs_pin_t pa_read = pa_sel & ~ans_q[5:0];
    wire pgs_pkg::pgs_reg_t pin_byte = {2'b00, pa_read};

    // ---------------- read mux ----------------
    // pin register shows the pins, latch register shows latches
    wire pgs_pkg::pgs_reg_t rd_byte =
        hit_pin ? pin_byte :
        hit_lat ? lat_q :
        hit_dir ? dir_q :
        hit_ans ? ans_q :
        hit_lvl ? lvl_q :
        hit_wpu ? wpu_q :
        hit_gpd ? {gpd_q, 7'h00} :
        hit_st0 ? st0_q :
        hit_st1 ? st1_q : 8'h00;

    // ---------------- next values ----------------
    // pin register write: pins read, addressed bits replaced, result
    // lands in the latch; a write with lane 0 off copies the pins back
    wire pgs_pkg::pgs_reg_t rmw_byte = lane0 ? wbyte : pin_byte;
    wire pgs_pkg::pgs_reg_t lat_d =
        wr_pin ? (rmw_byte & `PGS_MASK_LATCH) :
        wr_lat ? (wbyte & `PGS_MASK_LATCH) : lat_q;
    // bit 3 of direction stays one whatever is written
    wire pgs_pkg::pgs_reg_t dir_d = wr_dir ?
        ((wbyte & `PGS_MASK_DIR_WR) | `PGS_DIR_FIXED) : dir_q;
    wire pgs_pkg::pgs_reg_t ans_d = wr_ans ? (wbyte & `PGS_MASK_ANALOG) : ans_q;
    wire pgs_pkg::pgs_reg_t lvl_d = wr_lvl ? (wbyte & `PGS_MASK_PIN) : lvl_q;
    wire pgs_pkg::pgs_reg_t wpu_d = wr_wpu ? (wbyte & `PGS_MASK_PIN) : wpu_q;
    wire logic gpd_d = wr_gpd ? wbyte[`PGS_BIT_GLOBAL_PU] : gpd_q;
    wire pgs_pkg::pgs_reg_t st0_d = wr_st0 ? (wbyte & `PGS_MASK_STEER0) : st0_q;
    wire pgs_pkg::pgs_reg_t st1_d = wr_st1 ? (wbyte & `PGS_MASK_STEER1) : st1_q;

    // ---------------- steering selects ----------------
    wire logic rx_sel   = st0_q[`PGS_BIT_RX_SEL];
    wire logic sdo_sel  = st0_q[`PGS_BIT_SDO_SEL];
    wire logic ss_sel   = st0_q[`PGS_BIT_SS_SEL];
    wire logic gate_sel = st0_q[`PGS_BIT_GATE_SEL];
    wire logic tx_sel   = st0_q[`PGS_BIT_TX_SEL];
    wire logic pd_sel   = st1_q[`PGS_BIT_PWM_D_SEL];
    wire logic pc_sel   = st1_q[`PGS_BIT_PWM_C_SEL];
    wire logic p2b_sel  = st1_q[`PGS_BIT_PWM2_B_SEL];
    wire logic cap_sel  = st1_q[`PGS_BIT_CAP2_SEL];

    // ---------------- port a overrides ----------------
    // a steered peripheral output takes the pin without touching direction
    wire logic sdo_a  = sdo_sel & sdo_oe_i;
    wire logic p2b_a  = p2b_sel & pwm2_b_oe_i;
    wire pgs_pkg::pgs_pin_t ovr_a = {
        cap_sel & cap2_oe_i,
        sdo_a | p2b_a,
        1'b0,                                                  // input only
        1'b0,
        rx_sel & serial_receive_data_oe_i,
        tx_sel & serial_transmit_clock_oe_i };
    // spi data ranks above pwm2 b on the shared pin
    wire pgs_pkg::pgs_pin_t ovr_a_val = {
        cap2_out_i,
        sdo_a ? sdo_out_i : pwm2_b_out_i,
        1'b0,
        1'b0,
        serial_receive_data_out_i,
        serial_transmit_clock_out_i };

    // ---------------- port c overrides ----------------
    // unselected pins see no override at all
    wire logic sdo_c  = ~sdo_sel & sdo_oe_i;
    wire logic pd_c2  = ~pd_sel & pwm_d_oe_i;
    wire logic p2b_c  = ~p2b_sel & pwm2_b_oe_i;
    wire logic pc_c3  = ~pc_sel & pwm_c_oe_i;
    wire logic cap_c  = ~cap_sel & cap2_oe_i;
    wire pgs_pkg::pgs_pin_t ovr_c = {
        ~rx_sel & serial_receive_data_oe_i,
        ~tx_sel & serial_transmit_clock_oe_i,
        pc_c3 | cap_c,
        sdo_c | pd_c2 | p2b_c,
        pc_sel & pwm_c_oe_i,
        pd_sel & pwm_d_oe_i };
    // fixed ranking on shared port c pins
    wire logic c3_val = pc_c3 ? pwm_c_out_i : cap2_out_i;
    wire logic c2_val = sdo_c ? sdo_out_i : (pd_c2 ? pwm_d_out_i : pwm2_b_out_i);
    wire pgs_pkg::pgs_pin_t ovr_c_val = {
        serial_receive_data_out_i, serial_transmit_clock_out_i, c3_val, c2_val, pwm_c_out_i, pwm_d_out_i };

    // ---------------- pin drive ----------------
    // direction or a steered override gates the driver; analog select plays no part
    wire pgs_pkg::pgs_pin_t drv_on = (~dir_q[5:0] | ovr_a)
                                   & ~`PGS_INPUT_ONLY;
    wire pgs_pkg::pgs_pin_t drv_val = (ovr_a & ovr_a_val)
                                    | (~ovr_a & lat_q[5:0]);
    // pull-up only on inputs and only with the global disable clear
    wire pgs_pkg::pgs_pin_t pu_on = wpu_q[5:0] & ~drv_on
                                  & {6{~gpd_q}};

    // ---------------- steered peripheral inputs ----------------
    wire logic rx_in_d   = rx_sel   ? pa_read[1] : pc_s2_q[5];
    wire logic ck_in_d   = tx_sel   ? pa_read[0] : pc_s2_q[4];
    wire logic ss_in_d   = ss_sel   ? pa_read[3] : pc_s2_q[3];
    wire logic gate_in_d = gate_sel ? pa_read[3] : pa_read[4];
    wire logic cap_in_d  = cap_sel  ? pa_read[5] : pc_s2_q[3];

    // two-stage synchronisers for the pad levels
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_s1_q  <= 6'h00;
            st_s2_q  <= 6'h00;
            ttl_s1_q <= 6'h00;
            ttl_s2_q <= 6'h00;
            pc_s1_q  <= 6'h00;
            pc_s2_q  <= 6'h00;
        end else begin
            st_s1_q  <= pa_st_i;
            st_s2_q  <= st_s1_q;
            ttl_s1_q <= pa_ttl_i;
            ttl_s2_q <= ttl_s1_q;
            pc_s1_q  <= pc_pin_i;
            pc_s2_q  <= pc_s1_q;
        end
    end

    // configuration registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lat_q <= `PGS_RST_LATCH;
            dir_q <= `PGS_RST_DIRECTION;
            ans_q <= `PGS_RST_ANALOG;
            lvl_q <= `PGS_RST_THRESHOLD;
            wpu_q <= `PGS_RST_PULLUP;
            gpd_q <= `PGS_RST_GLOBAL_PU;
            st0_q <= `PGS_RST_STEER;
            st1_q <= `PGS_RST_STEER;
        end else begin
            lat_q <= lat_d;
            dir_q <= dir_d;
            ans_q <= ans_d;
            lvl_q <= lvl_d;
            wpu_q <= wpu_d;
            gpd_q <= gpd_d;
            st0_q <= st0_d;
            st1_q <= st1_d;
        end
    end

    // apb answer: one wait state, data captured with the ready flag
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= acc_first;
            pslverr_q <= acc_first & ~hit_any;
            if (acc_first) begin
                prdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    // registered pin and peripheral side outputs
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pa_out_q   <= 6'h00;
            pa_oe_q    <= 6'h00;
            pa_pu_q    <= 6'h00;
            pa_sense_q <= 6'h00;
            pc_en_q    <= 6'h00;
            pc_val_q   <= 6'h00;
            rx_in_q    <= 1'b0;
            ck_in_q    <= 1'b0;
            ss_in_q    <= 1'b0;
            gate_in_q  <= 1'b0;
            cap_in_q   <= 1'b0;
        end else begin
            pa_out_q   <= drv_val;
            pa_oe_q    <= drv_on;
            pa_pu_q    <= pu_on;
            pa_sense_q <= pa_read;
            pc_en_q    <= ovr_c;
            pc_val_q   <= ovr_c_val;
            rx_in_q    <= rx_in_d;
            ck_in_q    <= ck_in_d;
            ss_in_q    <= ss_in_d;
            gate_in_q  <= gate_in_d;
            cap_in_q   <= cap_in_d;
        end
    end

    // output wiring
    assign pready_o          = pready_q;
    assign prdata_o          = prdata_q;
    assign pslverr_o         = pslverr_q;
    assign pa_out_o          = pa_out_q;
    assign pa_oe_o           = pa_oe_q;
    assign pa_pullup_o       = pa_pu_q;
    assign pa_analog_o       = ans_q[5:0];
    assign pa_sense_o        = pa_sense_q;
    assign pc_ovr_en_o       = pc_en_q;
    assign pc_ovr_val_o      = pc_val_q;
    assign serial_receive_data_in_o        = rx_in_q;
    assign serial_transmit_clock_in_o        = ck_in_q;
    assign slave_select_in_o = ss_in_q;
    assign timer_gate_in_o   = gate_in_q;
    assign cap2_in_o         = cap_in_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // full-byte write to the pin level register
    sequence s_pin_wr;
        wr_pin && lane0;
    endsequence
    // read of a register starting its access
    sequence s_rd_pin;
        acc_first && !pwrite_i && hit_pin;
    endsequence

    chk_latch_write_same: assert property (
        s_pin_wr |=> lat_q == ($past(wbyte) & `PGS_MASK_LATCH))
        else $error("pin level write did not reach the latch");
    chk_latch_readback: assert property (
        (acc_first && !pwrite_i && hit_lat) |=> prdata_o[7:0] == $past(lat_q))
        else $error("latch read returned wrong data");
    chk_dir_drives_latch: assert property (
        (!dir_q[2]) |=> pa_oe_o[2] && pa_out_o[2] == $past(lat_q[2]))
        else $error("output pin did not drive latch");
    chk_bit3_input_only: assert property (
        dir_q[3] && !pa_oe_o[3])
        else $error("bit three drove or direction cleared");
    chk_upper_bits_zero: assert property (
        s_rd_pin |=> pready_o && prdata_o[31:6] == 26'h0)
        else $error("upper pin register bits not zero");
    chk_analog_reads_zero: assert property (
        (s_rd_pin ##0 ans_q[0]) |=> !prdata_o[0])
        else $error("analog pin read as one");
    chk_pullup_gating: assert property (
        (pa_pullup_o & ~$past(dir_q[5:0])) == 6'h00 && !($past(gpd_q) && |pa_pullup_o))
        else $error("pull-up on output or while globally disabled");
    chk_steer_keeps_dir: assert property (
        (wr_st0 || wr_st1) && !wr_dir |=> $stable(dir_q))
        else $error("steering write altered direction");
    chk_rx_steer: assert property (
        rx_sel |=> serial_receive_data_in_o == $past(pa_read[1]))
        else $error("serial receive not taken from port a bit 1");
    chk_tx_steer: assert property (
        (!tx_sel && serial_transmit_clock_oe_i) |=> pc_ovr_en_o[4] && !pa_oe_o[0] || !$past(dir_q[0]))
        else $error("serial transmit not on port c bit 4");

endmodule : pgs_port_a
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the port a gpio block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0] pstrb_i = 4'h1;
    logic pready_o, pslverr_o, er, serial_receive_data_in_o, serial_transmit_clock_in_o, slave_select_in_o, timer_gate_in_o;
    logic cap2_in_o;
    logic [5:0] pa_st_i, pa_ttl_i, pa_out_o, pa_oe_o, pa_pullup_o, pa_analog_o, pa_sense_o;
    logic [5:0] pc_ovr_en_o, pc_ovr_val_o, pc_pin_i = 6'h20, ext = 6'h08, skew = 6'h00;
    logic [5:0] ext_en = 6'h3f; // board drives the pins whose bit is set
    logic [6:0] p_out = 7'h00, p_oe = 7'h00; // rx,tx,sdo,pwm_c,pwm_d,pwm2_b,cap2
    int err_count = 0, n_compared = 0;
    localparam logic [7:0] ADR [9] = '{8'h04,8'h08,8'h0c,8'h10,8'h14,8'h18,8'h1c,8'h20,8'h24};
    localparam logic [7:0] RST [9] = '{8'h00,8'h3f,8'h17,8'h04,8'h3f,8'h80,8'h00,8'h00,8'h00};
    localparam logic [7:0] MSK [9] = '{8'h37,8'h3f,8'h17,8'h3f,8'h3f,8'h80,8'hec,8'h0f,8'h00};
    always #50 mclk_i = ~mclk_i;
    pgs_port_a dut (.mclk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .pa_st_i, .pa_ttl_i, .pa_out_o, .pa_oe_o,
        .pa_pullup_o, .pa_analog_o, .pa_sense_o, .pc_pin_i, .pc_ovr_en_o, .pc_ovr_val_o,
        .serial_receive_data_out_i(p_out[0]), .serial_receive_data_oe_i(p_oe[0]), .serial_transmit_clock_out_i(p_out[1]),
        .serial_transmit_clock_oe_i(p_oe[1]), .sdo_out_i(p_out[2]), .sdo_oe_i(p_oe[2]),
        .pwm_c_out_i(p_out[3]), .pwm_c_oe_i(p_oe[3]), .pwm_d_out_i(p_out[4]),
        .pwm_d_oe_i(p_oe[4]), .pwm2_b_out_i(p_out[5]), .pwm2_b_oe_i(p_oe[5]),
        .cap2_out_i(p_out[6]), .cap2_oe_i(p_oe[6]), .serial_receive_data_in_o, .serial_transmit_clock_in_o,
        .slave_select_in_o, .timer_gate_in_o, .cap2_in_o);
    pgs_pad_model pads (.out_i(pa_out_o), .oe_i(pa_oe_o), .pullup_i(pa_pullup_o), .ext_i(ext),
        .ext_en_i(ext_en), .skew_i(skew), .clk_i(mclk_i), .st_o(pa_st_i), .ttl_o(pa_ttl_i));
    // prints the counts and the verdict, then stops
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk
    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= {24'h000000, d};
        pstrb_i <= s;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        // pready, read data and error are taken at the same rising edge
        @(posedge mclk_i);
        while (pready_o !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            n++;
        end
        if (pready_o !== 1'b1) begin
            err_count++;
            test_done();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    // read one register, compare its word and its error flag
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic eexp);
        apb(1'b0, a, 8'h00, 4'h1);
        chk($sformatf("register %h", a), {24'h000000, exp}, rd);
        chk("slave error", {31'h0, eexp}, {31'h0, er});
    endtask : rdc
    initial begin
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        // reset values, then all ones written to every register but the pin level one, unmapped slot last
        for (int i = 0; i < 9; i++) rdc(ADR[i], RST[i], i == 8);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, ADR[i], 8'hff, 4'h1);
            rdc(ADR[i], MSK[i], i == 8);
        end
        chk("analog pins", 6'h17, pa_analog_o);
        $display("test registers done");
        apb(1'b1, 8'h00, 8'h15, 4'h1);
        rdc(8'h04, 8'h15, 1'b0);
        apb(1'b1, 8'h04, 8'h22, 4'h1);
        rdc(8'h04, 8'h22, 1'b0);
        apb(1'b1, 8'h08, 8'h00, 4'h1);
        rdc(8'h08, 8'h08, 1'b0);
        @(negedge mclk_i);
        chk("drive enable", 6'h37, pa_oe_o);
        chk("drive value", 6'h22, pa_out_o);
        rdc(8'h00, 8'h28, 1'b0);
        apb(1'b1, 8'h0c, 8'h00, 4'h1);
        rdc(8'h00, 8'h2a, 1'b0);
        skew <= 6'h08;
        repeat (4) @(posedge mclk_i);
        rdc(8'h00, 8'h2a, 1'b0);
        apb(1'b1, 8'h10, 8'h00, 4'h1);
        rdc(8'h00, 8'h22, 1'b0);
        @(negedge mclk_i);
        chk("change sense", 6'h22, pa_sense_o);
        @(posedge mclk_i);
        ext <= 6'h15;
        skew <= 6'h00;
        apb(1'b1, 8'h08, 8'h3f, 4'h1);
        repeat (4) @(posedge mclk_i);
        apb(1'b1, 8'h00, 8'hc0, 4'h0);
        rdc(8'h04, 8'h15, 1'b0);
        $display("test port done");
        @(negedge mclk_i);
        chk("pull-up gated", 6'h00, pa_pullup_o);
        apb(1'b1, 8'h18, 8'h00, 4'h1);
        repeat (2) @(negedge mclk_i);
        chk("pull-up on", 6'h3f, pa_pullup_o);
        // board lets go of the pins: the pull-ups alone set the levels
        @(posedge mclk_i);
        ext_en <= 6'h00;
        repeat (2) @(posedge mclk_i);
        rdc(8'h00, 8'h3f, 1'b0);
        ext_en <= 6'h3f;
        apb(1'b1, 8'h08, 8'h00, 4'h1);
        repeat (2) @(negedge mclk_i);
        chk("pull-up outputs", 6'h08, pa_pullup_o);
        $display("test pull-up done");
        // steering with serial transmit and capture2 driving
        @(posedge mclk_i);
        p_oe <= 7'h42;
        p_out <= 7'h42;
        apb(1'b1, 8'h08, 8'h3f, 4'h1);
        apb(1'b1, 8'h1c, 8'h04, 4'h1);
        apb(1'b1, 8'h20, 8'h00, 4'h1);
        repeat (4) @(negedge mclk_i);
        chk("pa steered", 7'h41, {pa_out_o[0], pa_oe_o});
        chk("pc steered", 6'h08, pc_ovr_en_o & pc_ovr_val_o);
        chk("steered inputs", 2'b11, {serial_receive_data_in_o, timer_gate_in_o});
        rdc(8'h08, 8'h3f, 1'b0);
        apb(1'b1, 8'h1c, 8'h88, 4'h1);
        apb(1'b1, 8'h20, 8'h01, 4'h1);
        repeat (4) @(negedge mclk_i);
        chk("pa moved", 6'h20, pa_oe_o);
        chk("pc moved", 6'h10, pc_ovr_en_o);
        chk("moved inputs", 2'b00, {serial_receive_data_in_o, timer_gate_in_o});
        // spi, pwm and pwm2 outputs steered, port c levels on the inputs
        @(posedge mclk_i);
        p_oe <= 7'h3c;
        p_out <= 7'h34;
        pc_pin_i <= 6'h18;
        apb(1'b1, 8'h1c, 8'h20, 4'h1);
        apb(1'b1, 8'h20, 8'h0e, 4'h1);
        repeat (4) @(negedge mclk_i);
        chk("pa pwm2 b", 6'h10, pa_oe_o & pa_out_o);
        chk("pc pwm", 12'h1c5, {pc_ovr_en_o, pc_ovr_val_o & pc_ovr_en_o});
        chk("pc inputs", 3'b101, {serial_transmit_clock_in_o, slave_select_in_o, cap2_in_o});
        apb(1'b1, 8'h1c, 8'h40, 4'h1);
        apb(1'b1, 8'h20, 8'h00, 4'h1);
        repeat (4) @(negedge mclk_i);
        chk("pa spi out", 6'h10, pa_oe_o & pa_out_o);
        chk("pc ranked", 12'h304, {pc_ovr_en_o, pc_ovr_val_o & pc_ovr_en_o});
        chk("pc inputs back", 3'b111, {serial_transmit_clock_in_o, slave_select_in_o, cap2_in_o});
        $display("test steering done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
